//--- uetrc_defines.vh
// Register offsets, field positions, thresholds and bus responses for the endpoint control block
`ifndef UETRC_DEFINES_VH
`define UETRC_DEFINES_VH
// Register byte addresses
`define UETRC_EPC_TX_ADDR    8'h00
`define UETRC_TXD_ADDR       8'h04
`define UETRC_TXS_ADDR       8'h08
`define UETRC_TXC_ADDR       8'h0C
`define UETRC_EPC_RX_ADDR    8'h10
`define UETRC_RXS_ADDR       8'h18
`define UETRC_RXC_ADDR       8'h1C
// Transmit command fields
`define UETRC_TXC_ARM        0
`define UETRC_TXC_LAST       1
`define UETRC_TXC_TOGGLE     2
`define UETRC_TXC_FLUSH      3
`define UETRC_TXC_REFILL     4
`define UETRC_TXC_WARN_LO    5
`define UETRC_TXC_BYPASS     7
// Endpoint control fields
`define UETRC_EPC_ISO        5
`define UETRC_EPC_STALL      7
// Receive command fields
`define UETRC_RXC_ARM        0
`define UETRC_RXC_IGNSETUP   2
`define UETRC_RXC_FLUSH      3
// Warning thresholds
`define UETRC_WARN_L1        7'h04
`define UETRC_WARN_L2        7'h08
`define UETRC_WARN_L3        7'h10
// FIFO geometry
`define UETRC_FIFO_DEPTH     64
`define UETRC_RX_CNT_SAT     7'h0F
`define UETRC_TX_FREE_SAT    7'h1F
// AXI responses
`define UETRC_RESP_OKAY      2'h0
`define UETRC_RESP_SLVERR    2'h2
`endif

//--- uetrc_endpoint.v
// Transmit and receive endpoint command and status logic with AXI4-Lite registers
`timescale 1ns/10ps
`include "uetrc_defines.vh"

// What this block does
// R1: Non-iso ack flag follows host ACK
// R2: Iso ack only on match or bypass; else flush
// R3: Transmit status read clears ack, underrun
// R4: Empty FIFO mid-packet sets underrun, stuff error
// R5: Software arms transmit; hardware disarms after packet
// R6: Packet-end bit; empty FIFO means zero-length
// R7: Clear packet-end after payload, CRC, EOP
// R8: Toggle picks DATA0/DATA1, never changed
// R9: Iso sends only on frame match unless bypassed, DATA0
// R10: Missed iso frame flushes at next SOF
// R11: Flush empties FIFO, deferred, self-clears
// R12: Packet-end saves pointer; refill restores it
// R13: Warn level selects 4, 8, 16 threshold
// R14: Warning only while transmit armed
// R15: Frame lock bypass sends on next IN
// R16: Data port takes payload only
// R17: Two receive status copies, zero-length SETUP second
// R18: Receive count saturates at 15
// R19: Receive complete on ACK or iso EOP
// R20: Receive toggle reports PID or frame bit
// R21: Software flushes FIFO on media error
// R22: Disarm receive after packet or STALL
// R23: Back-to-back SETUP discarded yet ACKed
// R24: Iso endpoint never sends NAK
module uetrc_endpoint (
  // Clock and reset
  input  wire        clk,
  input  wire        rst,
  // AXI4-Lite slave
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Transmit side link events from the serial engine
  input  wire        tx_in_token,
  input  wire        tx_pkt_done,
  input  wire        tx_host_ack,
  input  wire        tx_byte_take,
  input  wire        sof_event,
  input  wire        frame_number_lsb,
  output wire        tx_send_ok,
  output wire        tx_send_stall,
  output wire        tx_send_nak,
  output wire        tx_pid_data1,
  output reg  [7:0]  tx_fifo_byte,
  output wire        tx_fifo_empty,
  output wire        tx_force_stuff_err,
  output wire        tx_warn_event,
  // Receive side link events from the serial engine
  input  wire        rx_out_token,
  input  wire        rx_setup_token,
  input  wire        rx_other_token,
  input  wire        rx_byte_valid,
  input  wire [7:0]  rx_byte,
  input  wire        rx_pkt_good,
  input  wire        rx_pkt_eop,
  input  wire        rx_pid_data1,
  input  wire        rx_media_error,
  output wire        rx_send_ack,
  output wire        rx_send_nak,
  output wire        rx_send_stall,
  output wire        rx_active
);

  localparam PW = 6;

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  reg [7:0]    epc_tx_ff;
  reg [7:0]    epc_rx_ff;
  reg [7:0]    txc_ff;
  reg          tx_ack_ff;
  reg          tx_underrun_flag_ff;
  reg          tx_done_ff;
  reg [7:0]    tx_mem_ff [0:`UETRC_FIFO_DEPTH-1];
  reg [PW-1:0] tx_wp_ff;
  reg [PW-1:0] tx_read_pointer_ff;
  reg [PW-1:0] tx_saved_rp_ff;
  reg [PW:0]   tx_cnt_ff;
  reg          tx_busy_ff;
  reg          iso_window_ff;
  reg [PW:0]   rx_cnt_ff;
  reg [2:0]    rxc_ff;
  reg [6:0]    rxs_a_ff;
  reg          rxs_a_v_ff;
  reg [6:0]    rxs_b_ff;
  reg          rxs_b_v_ff;
  reg          rx_err_ff;
  reg          last_setup_ff;
  reg          rx_busy_ff;
  reg          aw_hold_ff;
  reg          w_hold_ff;
  reg [7:0]    aw_addr_ff;
  reg [31:0]   w_data_ff;
  reg          w_lane0_ff;
  integer      i;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write and read channel capture
  assign s_axi_awready = ~aw_hold_ff & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_hold_ff & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  wire [7:0] wr_addr = aw_hold_ff ? aw_addr_ff : s_axi_awaddr;
  wire [7:0] wr_data = w_hold_ff ? w_data_ff[7:0] : s_axi_wdata[7:0];
  wire       wr_lane = w_hold_ff ? w_lane0_ff : s_axi_wstrb[0];
  wire       aw_have = aw_hold_ff | (s_axi_awvalid & s_axi_awready);
  wire       w_have  = w_hold_ff | (s_axi_wvalid & s_axi_wready);
  wire       wr_go   = aw_have & w_have & ~s_axi_bvalid;
  wire       wr_en   = wr_go & wr_lane;
  wire       rd_go   = s_axi_arvalid & s_axi_arready;

  wire wr_txd = wr_en && (wr_addr == `UETRC_TXD_ADDR);
  wire wr_txc = wr_en && (wr_addr == `UETRC_TXC_ADDR);
  wire wr_rxc = wr_en && (wr_addr == `UETRC_RXC_ADDR);
  wire rd_txs = rd_go && (s_axi_araddr == `UETRC_TXS_ADDR);
  wire rd_rxs = rd_go && (s_axi_araddr == `UETRC_RXS_ADDR);

  // Address decode for write response
  reg wr_hit;
  always @*
  begin
    if (wr_addr == `UETRC_EPC_TX_ADDR || wr_addr == `UETRC_TXD_ADDR)
      wr_hit = 1'b1;
    else if (wr_addr == `UETRC_TXC_ADDR || wr_addr == `UETRC_EPC_RX_ADDR)
      wr_hit = 1'b1;
    else if (wr_addr == `UETRC_RXC_ADDR || wr_addr == `UETRC_TXS_ADDR)
      wr_hit = 1'b1;
    else if (wr_addr == `UETRC_RXS_ADDR)
      wr_hit = 1'b1;
    else
      wr_hit = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit qualification
  wire tx_iso     = epc_tx_ff[`UETRC_EPC_ISO];
  wire tx_stall   = epc_tx_ff[`UETRC_EPC_STALL];
  wire tx_arm     = txc_ff[`UETRC_TXC_ARM];
  wire tx_last    = txc_ff[`UETRC_TXC_LAST];
  wire tx_toggle  = txc_ff[`UETRC_TXC_TOGGLE];
  wire tx_bypass  = txc_ff[`UETRC_TXC_BYPASS];
  wire [1:0] tx_warn_level = txc_ff[`UETRC_TXC_WARN_LO+1:`UETRC_TXC_WARN_LO];
  wire frame_ok   = ~tx_iso | tx_bypass | (frame_number_lsb == tx_toggle); // R9 R15
  wire tx_ready   = tx_arm & frame_ok;
  wire tx_idle    = ~tx_busy_ff;
  wire tx_iso_win = tx_iso & tx_arm & ~tx_bypass & (frame_number_lsb == tx_toggle);

  assign tx_send_stall = tx_in_token & tx_stall;
  assign tx_send_ok    = tx_in_token & ~tx_stall & tx_ready;
  assign tx_send_nak   = tx_in_token & ~tx_stall & ~tx_ready & ~tx_iso; // R24
  assign tx_pid_data1  = ~tx_iso & tx_toggle; // R8 R9
  assign tx_fifo_empty = (tx_cnt_ff == {(PW+1){1'b0}});
  assign tx_force_stuff_err = tx_busy_ff & tx_byte_take & tx_fifo_empty & ~tx_last; // R4 R6

  // Warning threshold compare
  reg [PW:0] warn_lim;
  always @*
  begin
    case (tx_warn_level) // R13
      2'h1: warn_lim = `UETRC_WARN_L1;
      2'h2: warn_lim = `UETRC_WARN_L2;
      2'h3: warn_lim = `UETRC_WARN_L3;
      default: warn_lim = 7'h00;
    endcase
  end
  assign tx_warn_event = tx_arm & (tx_warn_level != 2'h0) & (tx_cnt_ff <= warn_lim); // R14

  ////////////////////////////////////////////////////////////////////////////
  // Transmit FIFO and command state
  wire tx_push = wr_txd & (tx_cnt_ff != `UETRC_FIFO_DEPTH); // R16
  wire tx_pop  = tx_busy_ff & tx_byte_take & ~tx_fifo_empty;
  wire iso_miss = sof_event & iso_window_ff & ~tx_busy_ff; // R10
  wire do_flush = txc_ff[`UETRC_TXC_FLUSH] & tx_idle;
  wire do_refill = txc_ff[`UETRC_TXC_REFILL] & tx_idle;

  always @(posedge clk)
  begin
    if (rst)
    begin
      txc_ff <= 8'h00;
      tx_ack_ff <= 1'b0;
      tx_underrun_flag_ff <= 1'b0;
      tx_done_ff <= 1'b0;
      tx_wp_ff <= {PW{1'b0}};
      tx_read_pointer_ff <= {PW{1'b0}};
      tx_saved_rp_ff <= {PW{1'b0}};
      tx_cnt_ff <= {(PW+1){1'b0}};
      tx_busy_ff <= 1'b0;
      iso_window_ff <= 1'b0;
      tx_fifo_byte <= 8'h00;
    end
    else
    begin
      // Status read clears, hardware set wins below
      if (rd_txs)
      begin
        tx_ack_ff <= 1'b0; // R3
        tx_underrun_flag_ff <= 1'b0; // R3
        tx_done_ff <= 1'b0;
      end
      if (wr_txc)
      begin
        txc_ff <= wr_data;
        if (wr_data[`UETRC_TXC_LAST] & ~tx_last)
          tx_saved_rp_ff <= tx_read_pointer_ff; // R12
      end
      iso_window_ff <= sof_event ? 1'b0 : (iso_window_ff | tx_iso_win);
      if (tx_send_ok)
        tx_busy_ff <= 1'b1;
      if (tx_force_stuff_err)
        tx_underrun_flag_ff <= 1'b1; // R4
      if (tx_push)
      begin
        tx_wp_ff <= tx_wp_ff + 6'h01;
      end
      if (tx_pop)
      begin
        tx_fifo_byte <= tx_mem_ff[tx_read_pointer_ff];
        tx_read_pointer_ff <= tx_read_pointer_ff + 6'h01;
      end
      if (tx_push & ~tx_pop)
        tx_cnt_ff <= tx_cnt_ff + 7'h01;
      else if (tx_pop & ~tx_push)
        tx_cnt_ff <= tx_cnt_ff - 7'h01;
      // End of a packet or stall answer
      if (tx_busy_ff & tx_pkt_done)
      begin
        tx_busy_ff <= 1'b0;
        tx_done_ff <= 1'b1;
        txc_ff[`UETRC_TXC_ARM] <= 1'b0; // R5
        txc_ff[`UETRC_TXC_LAST] <= 1'b0; // R7
        tx_ack_ff <= tx_iso ? 1'b1 : tx_host_ack; // R1 R2
      end
      else if (tx_send_stall)
      begin
        tx_done_ff <= 1'b1;
        txc_ff[`UETRC_TXC_ARM] <= 1'b0; // R5
      end
      // Missed iso frame: discard
      if (iso_miss)
      begin
        tx_ack_ff <= 1'b0; // R2
        tx_done_ff <= 1'b1; // R2
        tx_wp_ff <= {PW{1'b0}};
        tx_read_pointer_ff <= {PW{1'b0}};
        tx_cnt_ff <= {(PW+1){1'b0}};
      end
      // Deferred flush and refill
      if (do_flush)
      begin
        tx_wp_ff <= {PW{1'b0}}; // R11
        tx_read_pointer_ff <= {PW{1'b0}};
        tx_cnt_ff <= {(PW+1){1'b0}};
        txc_ff[`UETRC_TXC_FLUSH] <= 1'b0; // R11
        txc_ff[`UETRC_TXC_ARM] <= 1'b0;
        txc_ff[`UETRC_TXC_LAST] <= 1'b0;
      end
      else if (do_refill)
      begin
        tx_read_pointer_ff <= tx_saved_rp_ff; // R12
        tx_cnt_ff <= {1'b0, tx_wp_ff - tx_saved_rp_ff};
        txc_ff[`UETRC_TXC_REFILL] <= 1'b0; // R12
      end
    end
  end

  // FIFO storage
  always @(posedge clk)
  begin
    if (rst)
    begin
      for (i = 0; i < `UETRC_FIFO_DEPTH; i = i + 1)
        tx_mem_ff[i] <= 8'h00;
    end
    else if (tx_push)
      tx_mem_ff[tx_wp_ff] <= wr_data;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive side
  wire rx_iso   = epc_rx_ff[`UETRC_EPC_ISO];
  wire rx_stall = epc_rx_ff[`UETRC_EPC_STALL];
  wire rx_arm   = rxc_ff[`UETRC_RXC_ARM];
  wire rx_full  = (rx_cnt_ff == `UETRC_FIFO_DEPTH);
  wire setup_ok = rx_setup_token & ~rxc_ff[`UETRC_RXC_IGNSETUP];
  wire setup_dup = setup_ok & last_setup_ff; // R23
  wire setup_take = setup_ok & ~last_setup_ff & ~rxs_b_v_ff;
  wire out_stall = rx_out_token & rx_stall;
  wire out_take = rx_out_token & ~rx_stall & rx_arm & ~rx_full;
  wire rx_end = rx_busy_ff & (rx_pkt_good | rx_pkt_eop);
  wire rx_zero = (rx_cnt_ff == {(PW+1){1'b0}});
  wire rx_flush = rxc_ff[`UETRC_RXC_FLUSH] & ~rx_busy_ff;

  assign rx_send_stall = out_stall;
  assign rx_send_ack   = (out_take & ~rx_iso) | setup_take | setup_dup; // R23
  assign rx_send_nak   = rx_out_token & ~rx_stall & ~out_take & ~rx_iso; // R24
  assign rx_active     = rx_busy_ff;

  wire [3:0] rx_byte_count = (rx_cnt_ff > `UETRC_RX_CNT_SAT) ? 4'hF : rx_cnt_ff[3:0]; // R18
  wire       rx_tog_now = rx_iso ? frame_number_lsb : rx_pid_data1; // R20
  wire [6:0] rx_new_st = {rx_setup_token, rx_tog_now, 1'b1, 4'h0};

  always @(posedge clk)
  begin
    if (rst)
    begin
      rxc_ff <= 3'h0;
      rxs_a_ff <= 7'h00;
      rxs_a_v_ff <= 1'b0;
      rxs_b_ff <= 7'h00;
      rxs_b_v_ff <= 1'b0;
      rx_err_ff <= 1'b0;
      last_setup_ff <= 1'b0;
      rx_busy_ff <= 1'b0;
      rx_cnt_ff <= {(PW+1){1'b0}};
    end
    else
    begin
      if (wr_rxc)
        rxc_ff <= {wr_data[`UETRC_RXC_FLUSH], wr_data[`UETRC_RXC_IGNSETUP], wr_data[0]};
      // Read pops first copy, second moves up
      if (rd_rxs)
      begin
        rxs_a_ff <= rxs_b_ff; // R17
        rxs_a_v_ff <= rxs_b_v_ff;
        rxs_b_v_ff <= 1'b0;
        rxs_b_ff <= 7'h00;
        rx_err_ff <= 1'b0;
      end
      if (rx_setup_token | rx_out_token | rx_other_token)
        last_setup_ff <= setup_ok;
      if (out_take | setup_take)
        rx_busy_ff <= 1'b1;
      if (rx_busy_ff & rx_byte_valid & ~rx_full)
        rx_cnt_ff <= rx_cnt_ff + 7'h01;
      if (rx_busy_ff & rx_media_error)
        rx_err_ff <= 1'b1; // R21
      if (out_stall)
        rxc_ff[0] <= 1'b0; // R22
      if (rx_end)
      begin
        rx_busy_ff <= 1'b0;
        rxc_ff[0] <= 1'b0; // R22
        // Complete on good non-iso, or iso end of packet
        if (rx_iso | rx_pkt_good) // R19
        begin
          if ((rxs_a_v_ff & ~rd_rxs) | (rx_zero & rx_setup_token))
          begin
            rxs_b_ff <= rx_new_st; // R17
            rxs_b_v_ff <= 1'b1;
          end
          else
          begin
            rxs_a_ff <= rx_new_st;
            rxs_a_v_ff <= 1'b1;
          end
        end
      end
      if (rx_flush)
      begin
        rx_cnt_ff <= {(PW+1){1'b0}};
        rxc_ff[2] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Endpoint control and AXI response
  reg [7:0] rd_mux;
  reg       rd_hit;
  wire [6:0] tx_free_raw = 7'h40 - tx_cnt_ff;
  wire [4:0] tx_free = (`UETRC_FIFO_DEPTH - tx_cnt_ff > `UETRC_TX_FREE_SAT) ? 5'h1F
                       : tx_free_raw[4:0];

  always @*
  begin
    rd_hit = 1'b1;
    if (s_axi_araddr == `UETRC_EPC_TX_ADDR)
      rd_mux = epc_tx_ff;
    else if (s_axi_araddr == `UETRC_TXS_ADDR)
      rd_mux = {tx_underrun_flag_ff, tx_ack_ff, tx_done_ff, tx_free};
    else if (s_axi_araddr == `UETRC_TXC_ADDR)
      rd_mux = txc_ff;
    else if (s_axi_araddr == `UETRC_EPC_RX_ADDR)
      rd_mux = epc_rx_ff;
    else if (s_axi_araddr == `UETRC_RXS_ADDR)
      rd_mux = {rx_err_ff, rxs_a_ff[6:4], rx_byte_count};
    else if (s_axi_araddr == `UETRC_RXC_ADDR)
      rd_mux = {4'h0, rxc_ff[2], rxc_ff[1], 1'b0, rxc_ff[0]};
    else
    begin
      rd_mux = 8'h00;
      rd_hit = s_axi_araddr == `UETRC_TXD_ADDR;
    end
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      epc_tx_ff <= 8'h00;
      epc_rx_ff <= 8'h00;
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_data_ff <= 32'h00000000;
      w_lane0_ff <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= 32'h00000000;
    end
    else
    begin
      if (s_axi_awvalid & s_axi_awready & ~wr_go)
      begin
        aw_hold_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready & ~wr_go)
      begin
        w_hold_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_lane0_ff <= s_axi_wstrb[0];
      end
      if (wr_go)
      begin
        aw_hold_ff <= 1'b0;
        w_hold_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `UETRC_RESP_OKAY : `UETRC_RESP_SLVERR;
        if (wr_en && wr_addr == `UETRC_EPC_TX_ADDR)
          epc_tx_ff <= wr_data & 8'hBF;
        if (wr_en && wr_addr == `UETRC_EPC_RX_ADDR)
          epc_rx_ff <= wr_data & 8'hBF;
      end
      else if (s_axi_bvalid & s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (rd_go)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rd_mux};
        s_axi_rresp <= rd_hit ? `UETRC_RESP_OKAY : `UETRC_RESP_SLVERR;
      end
      else if (s_axi_rvalid & s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule // uetrc_endpoint

//--- uetrc_chk.sv
// Concurrent checks on the endpoint block ports
`timescale 1ns/10ps
`include "uetrc_defines.vh"
module uetrc_chk (
  // Clock and reset
  input wire        clk,
  input wire        rst,
  // Register bus
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [7:0]  s_axi_araddr,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  // Link side
  input wire        tx_in_token,
  input wire        tx_send_ok,
  input wire        tx_send_nak,
  input wire        tx_pid_data1,
  input wire        tx_fifo_empty,
  input wire        tx_force_stuff_err
);
  // One clock domain
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////////
  // Handshake steps
  sequence s_wr_ans;
    s_axi_bvalid && s_axi_bready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  // Bus answers
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped early");
  a_bvalid_drop: assert property (s_wr_ans |=> !s_axi_bvalid)
    else $error("write answer repeated");
  a_wr_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  a_rd_answer: assert property (s_rd_take |=> s_axi_rvalid)
    else $error("read answer late");
  a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer not held");
  a_unmapped_err: assert property (s_rd_take ##0 s_axi_araddr == 8'h14 |=> s_axi_rresp == `UETRC_RESP_SLVERR)
    else $error("unmapped read not refused");
  // Link answers
  a_stuff_empty: assert property (tx_force_stuff_err |-> tx_fifo_empty)
    else $error("stuff error with data left");
  a_tx_on_token: assert property (tx_send_ok || tx_send_nak |-> tx_in_token)
    else $error("transmit answer without token");
  a_pid_fixed: assert property ($changed(tx_pid_data1) |-> $past(s_axi_wvalid) || $past(s_axi_wvalid, 2))
    else $error("data pid changed without a write");
endmodule // uetrc_chk

//--- uetrc_host_model.sv
// Host and serial engine model driving the endpoint link events
`timescale 1ns/10ps
module uetrc_host_model #(
  parameter GAP = 0
) (
  // Clock
  input  wire       clk,
  // Link events toward the endpoint
  output reg        tx_in_token,
  output reg        tx_pkt_done,
  output reg        tx_host_ack,
  output reg        tx_byte_take,
  output reg        frame_number_lsb,
  output reg        rx_out_token,
  output reg        rx_byte_valid,
  output reg  [7:0] rx_byte,
  output reg        rx_pkt_good,
  output reg        rx_pkt_eop,
  output reg        rx_pid_data1,
  // Endpoint answers
  input  wire       tx_send_ok,
  input  wire       tx_send_nak,
  input  wire       tx_pid_data1,
  input  wire [7:0] tx_fifo_byte,
  input  wire       tx_force_stuff_err,
  input  wire       rx_send_ack
);
  reg [15:0] got;
  reg        stuff_seen;
  // Idle link
  initial
  begin
    {tx_in_token, tx_pkt_done, tx_host_ack, tx_byte_take, frame_number_lsb} = 5'h00;
    {rx_out_token, rx_byte_valid, rx_pkt_good, rx_pkt_eop, rx_pid_data1} = 5'h00;
    rx_byte = 8'h00;
    got = 16'h0000;
    stuff_seen = 1'b0;
  end
  // Remember a forced stuff error
  always @(posedge clk)
    if (tx_force_stuff_err)
      stuff_seen <= 1'b1;
  ////////////////////////////////////////////////////////////////////////////////
  // IN token, answer taken in the token cycle
  task in_tok(output [2:0] ans);
    begin
      tx_in_token <= 1'b1;
      @(negedge clk);
      ans = {tx_send_ok, tx_send_nak, tx_pid_data1};
      @(posedge clk);
      tx_in_token <= 1'b0;
      @(posedge clk);
    end
  endtask
  // Engine takes n bytes, then the packet ends with the host handshake
  task take(input integer n, input ack);
    integer k;
    begin
      for (k = 0; k < n; k = k + 1)
      begin
        tx_byte_take <= 1'b1;
        @(posedge clk);
        tx_byte_take <= 1'b0;
        @(negedge clk);
        got = {got[7:0], tx_fifo_byte};
        @(posedge clk);
        repeat (GAP) @(posedge clk);
      end
      tx_pkt_done <= 1'b1;
      tx_host_ack <= ack;
      @(posedge clk);
      tx_pkt_done <= 1'b0;
      tx_host_ack <= ~ack;  // Not held past done
      @(posedge clk);
    end
  endtask
  // OUT token, then data and a good end when acked
  task out_pkt(input integer n, input pid1, output ack);
    integer k;
    begin
      rx_out_token <= 1'b1;
      @(negedge clk);
      ack = rx_send_ack;
      @(posedge clk);
      rx_out_token <= 1'b0;
      if (ack)
      begin
        for (k = 0; k < n; k = k + 1)
        begin
          rx_byte_valid <= 1'b1;
          rx_byte <= k[7:0] ^ 8'h5A;
          @(posedge clk);
        end
        rx_byte_valid <= 1'b0;
        rx_byte <= ~rx_byte;  // Released bus does not keep the byte
        rx_pid_data1 <= pid1;
        {rx_pkt_good, rx_pkt_eop} <= 2'h3;
        @(posedge clk);
        {rx_pkt_good, rx_pkt_eop} <= 2'h0;
        rx_pid_data1 <= ~pid1;
      end
      @(posedge clk);
    end
  endtask
endmodule // uetrc_host_model

//--- tb_usb_endpoint_tx_rx_control.sv
// Self-checking bench for the endpoint command and status block
`timescale 1ns/10ps
`include "uetrc_defines.vh"
module tb_usb_endpoint_tx_rx_control;
  reg         clk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  reg  [7:0]  s_axi_awaddr, s_axi_araddr;
  reg  [31:0] s_axi_wdata, rd;
  reg  [3:0]  s_axi_wstrb;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire        tx_in_token, tx_pkt_done, tx_host_ack, tx_byte_take, frame_number_lsb, tx_send_ok;
  wire        tx_send_nak, tx_pid_data1, tx_fifo_empty, tx_force_stuff_err, tx_warn_event;
  wire        rx_out_token, rx_byte_valid, rx_pkt_good, rx_pkt_eop, rx_pid_data1, rx_send_ack;
  wire [7:0]  tx_fifo_byte, rx_byte;
  integer     err_count, compares;
  reg  [1:0]  resp;
  reg  [2:0]  ans;
  reg         ack;
  // Device under test
  uetrc_endpoint i_dut (
    .*, .sof_event(1'b0), .rx_setup_token(1'b0), .rx_other_token(1'b0), .rx_media_error(1'b0),
    .tx_send_stall(), .rx_send_nak(), .rx_send_stall(), .rx_active()
  );
  // Far side, slow byte takes
  uetrc_host_model #(.GAP(2)) i_host (.*);
  // Clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task check(input [8*12:1] what, input [31:0] seen, input [31:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp)
      begin
        err_count = err_count + 1;
        $display("Error %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  // Verdict and end of run
  task final_report;
    begin
      if (err_count == 0 && compares > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  // Register write, address and data offered together
  task axi_wr(input [7:0] a, input [7:0] d);
    integer n;
    reg aw, w, b;
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h000000, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      b = 1'b0;
      for (n = 0; n < 50 && !b; n = n + 1)
      begin
        @(negedge clk);
        aw = s_axi_awvalid && s_axi_awready;
        w = s_axi_wvalid && s_axi_wready;
        b = s_axi_bvalid;
        @(posedge clk);
        if (aw) s_axi_awvalid <= 1'b0;
        if (w) s_axi_wvalid <= 1'b0;
      end
      if (!b)
      begin
        err_count = err_count + 1;
        final_report;
      end
    end
  endtask
  // Register read
  task axi_rd(input [7:0] a, output [31:0] d, output [1:0] r);
    integer n;
    reg ar, v;
    begin
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      v = 1'b0;
      for (n = 0; n < 50 && !v; n = n + 1)
      begin
        @(negedge clk);
        ar = s_axi_arvalid && s_axi_arready;
        v = s_axi_rvalid;
        d = s_axi_rdata;
        r = s_axi_rresp;
        @(posedge clk);
        if (ar) s_axi_arvalid <= 1'b0;
      end
      if (!v)
      begin
        err_count = err_count + 1;
        final_report;
      end
    end
  endtask
  // Read and compare one register
  task rdchk(input [7:0] a, input [7:0] exp, input [8*12:1] what);
    begin
      axi_rd(a, rd, resp);
      check(what, rd, {24'h000000, exp});
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    err_count = 0;
    compares = 0;
    rst = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hF;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // Reset values and an unmapped place
    rdchk(`UETRC_RXS_ADDR, 8'h00, "rx_status");
    rdchk(`UETRC_TXC_ADDR, 8'h00, "tx_command");
    axi_rd(8'h14, rd, resp);
    check("unmapped", resp, `UETRC_RESP_SLVERR);
    // Two byte packet, DATA1, warning only once armed
    axi_wr(`UETRC_TXC_ADDR, 8'h24);
    axi_wr(`UETRC_TXD_ADDR, 8'hA5);
    axi_wr(`UETRC_TXD_ADDR, 8'h3C);
    @(negedge clk);
    check("warn_idle", tx_warn_event, 1'b0);
    @(posedge clk);
    axi_wr(`UETRC_TXC_ADDR, 8'h27);
    @(negedge clk);
    check("warn_armed", tx_warn_event, 1'b1);
    @(posedge clk);
    i_host.in_tok(ans);
    check("in_answer", ans, 3'b101);
    i_host.take(2, 1'b1);
    check("payload", i_host.got, 16'hA53C);
    rdchk(`UETRC_TXS_ADDR, 8'h7F, "tx_status");
    rdchk(`UETRC_TXS_ADDR, 8'h1F, "tx_status");
    rdchk(`UETRC_TXC_ADDR, 8'h24, "tx_command");
    // Engine outruns software, no host ack
    axi_wr(`UETRC_TXD_ADDR, 8'h11);
    axi_wr(`UETRC_TXC_ADDR, 8'h01);
    i_host.in_tok(ans);
    i_host.take(2, 1'b0);
    check("stuff_err", i_host.stuff_seen, 1'b1);
    axi_rd(`UETRC_TXS_ADDR, rd, resp);
    check("underrun", rd[7:6], 2'b10);
    // Flush a loaded FIFO
    axi_wr(`UETRC_TXD_ADDR, 8'h22);
    axi_wr(`UETRC_TXC_ADDR, 8'h08);
    rdchk(`UETRC_TXC_ADDR, 8'h00, "tx_command");
    @(negedge clk);
    check("flushed", tx_fifo_empty, 1'b1);
    @(posedge clk);
    // Iso zero-length packet locked to odd frames
    axi_wr(`UETRC_EPC_TX_ADDR, 8'h20);
    axi_wr(`UETRC_TXC_ADDR, 8'h07);
    i_host.in_tok(ans);
    check("iso_miss", ans[2:1], 2'b00);
    i_host.frame_number_lsb <= 1'b1;
    @(posedge clk);
    i_host.in_tok(ans);
    check("iso_hit", ans, 3'b100);
    i_host.take(0, 1'b0);
    rdchk(`UETRC_TXS_ADDR, 8'h7F, "iso_status");
    // Receive, disarm, flush, saturation
    axi_wr(`UETRC_RXC_ADDR, 8'h01);
    i_host.out_pkt(3, 1'b1, ack);
    check("rx_ack", ack, 1'b1);
    rdchk(`UETRC_RXS_ADDR, 8'h33, "rx_status");
    rdchk(`UETRC_RXS_ADDR, 8'h03, "rx_status");
    i_host.out_pkt(1, 1'b0, ack);
    check("rx_disarmed", ack, 1'b0);
    axi_wr(`UETRC_RXC_ADDR, 8'h08);
    axi_wr(`UETRC_RXC_ADDR, 8'h01);
    i_host.out_pkt(20, 1'b0, ack);
    rdchk(`UETRC_RXS_ADDR, 8'h1F, "rx_status");
    final_report;
  end
endmodule // tb_usb_endpoint_tx_rx_control

// Checker beside the design
bind uetrc_endpoint uetrc_chk i_chk (.*);
